// [dmr_result_regs.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dmr_defines.svh"

module dmr_result_regs
(
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             result_valid_i,
  input  wire logic [3:0]       result_source_id_i,
  input  wire logic [11:0]      result_data_i,
  input  wire logic             freeze_monitor_results_i,
  input  wire logic             reg_rd_en_i,
  input  wire logic             reg_wr_en_i,
  input  wire logic [7:0]       reg_addr_i,
  output logic      [7:0]       reg_rd_data_o,
  output logic                  reg_rd_valid_o,
  output logic                  reg_addr_hit_o,
  output logic                  reg_wr_ack_o,
  output logic                  result_dropped_o
);

  dmr_pkg::dmr_result_t  out2_pos_result_reg;
  dmr_pkg::dmr_result_t  out2_neg_result_reg;
  dmr_pkg::dmr_result_t  temperature_result_reg;
  dmr_pkg::dmr_result_t  micbias_load_result_reg;
  dmr_pkg::dmr_result_t  analog_supply_result_reg;
  dmr_pkg::dmr_result_t  gp_analog_result_reg;
  logic                  rd_data_valid_reg;
  dmr_pkg::dmr_byte_t    rd_data_reg;
  logic                  wr_ack_reg;
  logic                  dropped_reg;

  logic                  src_hit;
  dmr_pkg::dmr_channel_e src_ch;
  logic                  addr_hit;
  dmr_pkg::dmr_channel_e addr_ch;
  dmr_pkg::dmr_addr_t    scan_addr;
  logic                  result_accept;
  logic                  result_refused;
  logic [5:0]            load_en;
  dmr_pkg::dmr_result_t  stored_word;
  dmr_pkg::dmr_byte_t    rd_data_next;

  // source identifier of a channel
  function automatic dmr_pkg::dmr_id_t ch_id(input dmr_pkg::dmr_channel_e ch);
    dmr_pkg::dmr_id_t id;
    id = `DMR_ID_OUT2_POS;
    unique case (ch)
      dmr_pkg::DMR_CH_OUT2_POS:      id = `DMR_ID_OUT2_POS;
      dmr_pkg::DMR_CH_OUT2_NEG:      id = `DMR_ID_OUT2_NEG;
      dmr_pkg::DMR_CH_TEMPERATURE:   id = `DMR_ID_TEMPERATURE;
      dmr_pkg::DMR_CH_MICBIAS_LOAD:  id = `DMR_ID_MICBIAS_LOAD;
      dmr_pkg::DMR_CH_ANALOG_SUPPLY: id = `DMR_ID_ANALOG_SUPPLY;
      dmr_pkg::DMR_CH_GP_ANALOG:     id = `DMR_ID_GP_ANALOG;
      default:                       id = `DMR_ID_OUT2_POS;
    endcase
    return id;
  endfunction

  // offset of a channel's high register
  function automatic dmr_pkg::dmr_addr_t ch_high_addr(input dmr_pkg::dmr_channel_e ch);
    dmr_pkg::dmr_addr_t a;
    a = `DMR_OUT2_POS_RESULT_HIGH_ADDR;
    unique case (ch)
      dmr_pkg::DMR_CH_OUT2_POS:      a = `DMR_OUT2_POS_RESULT_HIGH_ADDR;
      dmr_pkg::DMR_CH_OUT2_NEG:      a = `DMR_OUT2_NEG_RESULT_HIGH_ADDR;
      dmr_pkg::DMR_CH_TEMPERATURE:   a = `DMR_TEMPERATURE_RESULT_HIGH_ADDR;
      dmr_pkg::DMR_CH_MICBIAS_LOAD:  a = `DMR_MICBIAS_LOAD_RESULT_HIGH_ADDR;
      dmr_pkg::DMR_CH_ANALOG_SUPPLY: a = `DMR_ANALOG_SUPPLY_RESULT_HIGH_ADDR;
      dmr_pkg::DMR_CH_GP_ANALOG:     a = `DMR_GP_ANALOG_RESULT_HIGH_ADDR;
      default:                       a = `DMR_OUT2_POS_RESULT_HIGH_ADDR;
    endcase
    return a;
  endfunction

  // high register view: upper eight bits of the stored word
  function automatic dmr_pkg::dmr_byte_t high_byte(input dmr_pkg::dmr_result_t word);
    return word[`DMR_HIGH_MSB:`DMR_HIGH_LSB];
  endfunction

  // low register view: lowest nibble above the fixed source identifier
  function automatic dmr_pkg::dmr_byte_t low_byte(input dmr_pkg::dmr_result_t word,
                                                  input dmr_pkg::dmr_id_t     id);
    dmr_pkg::dmr_byte_t b;
    b = `DMR_UNMAPPED_RDATA;
    b[`DMR_FIELD_NIBBLE_MSB:`DMR_FIELD_NIBBLE_LSB] = word[`DMR_LOW_MSB:`DMR_LOW_LSB];
    b[`DMR_FIELD_ID_MSB:`DMR_FIELD_ID_LSB]         = id;
    return b;
  endfunction

  // match the incoming source identifier and the bus address against the channels
  always_comb
  begin
    src_hit  = 1'b0;
    src_ch   = dmr_pkg::DMR_CH_OUT2_POS;
    addr_hit = 1'b0;
    addr_ch  = dmr_pkg::DMR_CH_OUT2_POS;
    scan_addr = `DMR_OUT2_POS_RESULT_HIGH_ADDR;
    for (int i = 0; i < dmr_pkg::DMR_NUM_CH; i++)
    begin
      scan_addr = ch_high_addr(dmr_pkg::dmr_channel_e'(i[2:0]));
      if (result_source_id_i == ch_id(dmr_pkg::dmr_channel_e'(i[2:0])))
      begin
        src_hit = 1'b1;
        src_ch  = dmr_pkg::dmr_channel_e'(i[2:0]);
      end
      // a pair shares every address bit but the lowest
      if (reg_addr_i[7:1] == scan_addr[7:1])
      begin
        addr_hit = 1'b1;
        addr_ch  = dmr_pkg::dmr_channel_e'(i[2:0]);
      end
    end
  end

  // a result is taken only for a known source while updates are not frozen
  assign result_accept  = result_valid_i && src_hit && !freeze_monitor_results_i;
  assign result_refused = result_valid_i && src_hit && freeze_monitor_results_i;

  // one load enable per channel, so a word lands in exactly one place
  always_comb
  begin
    load_en = 6'h00;
    if (result_accept)
    begin
      load_en[src_ch] = 1'b1;
    end
  end

  // output 2 plus: whole word loaded at once, so both halves always hold one conversion
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      out2_pos_result_reg <= `DMR_RESULT_RESET;
    end
    else if (load_en[dmr_pkg::DMR_CH_OUT2_POS])
    begin
      out2_pos_result_reg <= result_data_i;
    end
  end

  // output 2 minus
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      out2_neg_result_reg <= `DMR_RESULT_RESET;
    end
    else if (load_en[dmr_pkg::DMR_CH_OUT2_NEG])
    begin
      out2_neg_result_reg <= result_data_i;
    end
  end

  // temperature
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      temperature_result_reg <= `DMR_RESULT_RESET;
    end
    else if (load_en[dmr_pkg::DMR_CH_TEMPERATURE])
    begin
      temperature_result_reg <= result_data_i;
    end
  end

  // mic-bias load
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      micbias_load_result_reg <= `DMR_RESULT_RESET;
    end
    else if (load_en[dmr_pkg::DMR_CH_MICBIAS_LOAD])
    begin
      micbias_load_result_reg <= result_data_i;
    end
  end

  // analog supply
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      analog_supply_result_reg <= `DMR_RESULT_RESET;
    end
    else if (load_en[dmr_pkg::DMR_CH_ANALOG_SUPPLY])
    begin
      analog_supply_result_reg <= result_data_i;
    end
  end

  // general-purpose analog input
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      gp_analog_result_reg <= `DMR_RESULT_RESET;
    end
    else if (load_en[dmr_pkg::DMR_CH_GP_ANALOG])
    begin
      gp_analog_result_reg <= result_data_i;
    end
  end

  // stored word of the addressed pair
  always_comb
  begin
    stored_word = `DMR_RESULT_RESET;
    unique case (addr_ch)
      dmr_pkg::DMR_CH_OUT2_POS:      stored_word = out2_pos_result_reg;
      dmr_pkg::DMR_CH_OUT2_NEG:      stored_word = out2_neg_result_reg;
      dmr_pkg::DMR_CH_TEMPERATURE:   stored_word = temperature_result_reg;
      dmr_pkg::DMR_CH_MICBIAS_LOAD:  stored_word = micbias_load_result_reg;
      dmr_pkg::DMR_CH_ANALOG_SUPPLY: stored_word = analog_supply_result_reg;
      dmr_pkg::DMR_CH_GP_ANALOG:     stored_word = gp_analog_result_reg;
      default:                       stored_word = `DMR_RESULT_RESET;
    endcase
  end

  // read mux: high byte, or low nibble above the fixed identifier
  always_comb
  begin
    rd_data_next = `DMR_UNMAPPED_RDATA;
    if (addr_hit)
    begin
      if (reg_addr_i[0])
      begin
        rd_data_next = low_byte(stored_word, ch_id(addr_ch));
      end
      else
      begin
        rd_data_next = high_byte(stored_word);
      end
    end
  end

  // flags a conversion discarded because results are frozen; nothing is queued
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dropped_reg <= 1'b0;
    end
    else
    begin
      dropped_reg <= result_refused;
    end
  end

  // read data holds until the next read; reading changes no stored state
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_data_reg <= `DMR_RDATA_RESET;
    end
    else if (reg_rd_en_i)
    begin
      rd_data_reg <= rd_data_next;
    end
  end

  // read valid follows every read strobe by one cycle
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_data_valid_reg <= 1'b0;
    end
    else
    begin
      rd_data_valid_reg <= reg_rd_en_i;
    end
  end

  // writes are only acknowledged; a read in the same cycle takes precedence
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_ack_reg <= 1'b0;
    end
    else
    begin
      wr_ack_reg <= reg_wr_en_i && !reg_rd_en_i;
    end
  end

  assign reg_rd_data_o    = rd_data_reg;
  assign reg_rd_valid_o   = rd_data_valid_reg;
  assign reg_addr_hit_o   = addr_hit;
  assign reg_wr_ack_o     = wr_ack_reg;
  assign result_dropped_o = dropped_reg;

endmodule

`default_nettype wire

// [dmr_defines.svh]
`ifndef DMR_DEFINES_SVH
`define DMR_DEFINES_SVH

// register offsets of the result pairs; the low register follows its high one
`define DMR_OUT2_POS_RESULT_HIGH_ADDR     8'h66
`define DMR_OUT2_POS_RESULT_LOW_ID_ADDR   8'h67
`define DMR_OUT2_NEG_RESULT_HIGH_ADDR     8'h68
`define DMR_OUT2_NEG_RESULT_LOW_ID_ADDR   8'h69
`define DMR_TEMPERATURE_RESULT_HIGH_ADDR  8'h6A
`define DMR_TEMPERATURE_RESULT_LOW_ID_ADDR 8'h6B
`define DMR_MICBIAS_LOAD_RESULT_HIGH_ADDR 8'h6C
`define DMR_MICBIAS_LOAD_RESULT_LOW_ID_ADDR 8'h6D
`define DMR_ANALOG_SUPPLY_RESULT_HIGH_ADDR 8'h6E
`define DMR_ANALOG_SUPPLY_RESULT_LOW_ID_ADDR 8'h6F
`define DMR_GP_ANALOG_RESULT_HIGH_ADDR    8'h70
`define DMR_GP_ANALOG_RESULT_LOW_ID_ADDR  8'h71

// source identifiers held in bits 3..0 of each low register
`define DMR_ID_OUT2_POS                   4'h8
`define DMR_ID_OUT2_NEG                   4'h9
`define DMR_ID_TEMPERATURE                4'hA
`define DMR_ID_MICBIAS_LOAD               4'hB
`define DMR_ID_ANALOG_SUPPLY              4'hC
`define DMR_ID_GP_ANALOG                  4'hD

// field layout
`define DMR_HIGH_MSB                      11
`define DMR_HIGH_LSB                      4
`define DMR_LOW_MSB                       3
`define DMR_LOW_LSB                       0
`define DMR_FIELD_NIBBLE_MSB              7
`define DMR_FIELD_NIBBLE_LSB              4
`define DMR_FIELD_ID_MSB                  3
`define DMR_FIELD_ID_LSB                  0

// reset values
`define DMR_RESULT_RESET                  12'h000
`define DMR_RDATA_RESET                   8'h00
`define DMR_UNMAPPED_RDATA                8'h00

`endif

// [dmr_pkg.sv]
`default_nettype none
package dmr_pkg;

  typedef logic [11:0] dmr_result_t;
  typedef logic [7:0]  dmr_byte_t;
  typedef logic [3:0]  dmr_id_t;
  typedef logic [7:0]  dmr_addr_t;

  // monitored quantities in address order
  typedef enum logic [2:0]
  {
    DMR_CH_OUT2_POS,
    DMR_CH_OUT2_NEG,
    DMR_CH_TEMPERATURE,
    DMR_CH_MICBIAS_LOAD,
    DMR_CH_ANALOG_SUPPLY,
    DMR_CH_GP_ANALOG
  } dmr_channel_e;

  localparam int unsigned DMR_NUM_CH = 6;

endpackage
`default_nettype wire

// [dmr_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module dmr_monitor
(
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        result_valid_i,
  input wire logic [3:0]  result_source_id_i,
  input wire logic [11:0] result_data_i,
  input wire logic        freeze_monitor_results_i,
  input wire logic        reg_rd_en_i,
  input wire logic        reg_wr_en_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  reg_rd_data_o,
  input wire logic        reg_rd_valid_o,
  input wire logic        reg_addr_hit_o,
  input wire logic        reg_wr_ack_o,
  input wire logic        result_dropped_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic hit;
  logic known;
  assign hit = reg_addr_i >= 8'h66 && reg_addr_i <= 8'h71;
  assign known = result_source_id_i >= 4'h8 && result_source_id_i <= 4'hD;
  property p_hit; hit == reg_addr_hit_o; endproperty
  a_hit: assert property (p_hit) else $error("address decode wrong");
  property p_id; reg_rd_en_i && hit && reg_addr_i[0]
    |=> reg_rd_data_o[3:0] == 4'((($past(reg_addr_i) - 8'h67) >> 1) + 8'h08); endproperty
  a_id: assert property (p_id) else $error("source id wrong");
  property p_unm; reg_rd_en_i && !hit |=> reg_rd_data_o == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_hold; !reg_rd_en_i |=> $stable(reg_rd_data_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_rdv; reg_rd_en_i |=> reg_rd_valid_o; endproperty
  a_rdv: assert property (p_rdv) else $error("read valid missing");
  property p_ack; reg_wr_en_i && !reg_rd_en_i |=> reg_wr_ack_o && !reg_rd_valid_o; endproperty
  a_ack: assert property (p_ack) else $error("write ack wrong");
  property p_drp; result_valid_i && freeze_monitor_results_i && known |=> result_dropped_o;
  endproperty
  a_drp: assert property (p_drp) else $error("drop pulse missing");
  property p_ndrp; !(result_valid_i && freeze_monitor_results_i) |=> !result_dropped_o;
  endproperty
  a_ndrp: assert property (p_ndrp) else $error("spurious drop pulse");
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk = 0, rst_b = 0, vld = 0, frz = 0, rd = 0, wr = 0;
  logic [3:0]  sid = 0;
  logic [11:0] dat = 0, m [6];
  logic [7:0]  adr = 0, rdat;
  logic        rdv, hit, ack, drp;
  int          failures = 0, n_tests = 0;
  dmr_result_regs dut_u (.clk_i(clk), .rst_b_i(rst_b), .result_valid_i(vld),
    .result_source_id_i(sid), .result_data_i(dat), .freeze_monitor_results_i(frz),
    .reg_rd_en_i(rd), .reg_wr_en_i(wr), .reg_addr_i(adr), .reg_rd_data_o(rdat),
    .reg_rd_valid_o(rdv), .reg_addr_hit_o(hit), .reg_wr_ack_o(ack), .result_dropped_o(drp));
  initial forever #2.5 clk = ~clk;
  task automatic test_done;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    logic [2:0] c;
    c = 3'((a - 8'h66) >> 1);
    if (a < 8'h66 || a > 8'h71)
      return 8'h00;
    return a[0] ? {m[c][3:0], 4'h8 + 4'(c)} : m[c][11:4];
  endfunction
  task automatic rd_chk(input logic [7:0] a);
    @(posedge clk);
    rd <= 1;
    adr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk_byte(rdat, exp_rd(a));
    chk_bit(rdv, 1'b1);
    chk_bit(hit, a >= 8'h66 && a <= 8'h71);
  endtask
  task automatic push(input logic [3:0] id, input logic [11:0] d, input logic f);
    @(posedge clk);
    vld <= 1;
    sid <= id;
    dat <= d;
    frz <= f;
    @(posedge clk);
    vld <= 0;
    if (id >= 8 && id <= 13 && !f)
      m[id - 8] = d;
    #1 chk_bit(drp, f && id >= 8 && id <= 13);
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic r);
    @(posedge clk);
    wr <= 1;
    rd <= r;
    adr <= a;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1 chk_bit(ack, !r);
    chk_bit(rdv, r);
    if (r)
      chk_byte(rdat, exp_rd(a));
  endtask
  initial
  begin
    #20000;
    failures++;
    test_done;
  end
  initial
  begin
    void'($urandom(41454));
    for (int i = 0; i < 6; i++)
      m[i] = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1;
    for (int a = 8'h64; a < 8'h74; a++)
      rd_chk(8'(a));
    repeat (60)
    begin
      push(4'($urandom_range(15, 6)), 12'($urandom), ($urandom % 4) == 0);
      wr_chk(8'($urandom_range(8'h71, 8'h66)), 1'b0);
      rd_chk(8'($urandom_range(8'h73, 8'h64)));
    end
    wr_chk(8'h6B, 1'b1);
    @(posedge clk);
    rst_b <= 0;
    for (int i = 0; i < 6; i++)
      m[i] = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1;
    for (int a = 8'h66; a < 8'h72; a++)
      rd_chk(8'(a));
    push(4'hA, 12'hABC, 0);
    push(4'hA, 12'h123, 1);
    for (int a = 8'h66; a < 8'h72; a++)
      rd_chk(8'(a));
    push(4'hA, 12'h456, 0);
    rd_chk(8'h6A);
    rd_chk(8'h6B);
    test_done;
  end
endmodule
bind dmr_result_regs dmr_monitor mon_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .result_valid_i(result_valid_i), .result_source_id_i(result_source_id_i),
  .result_data_i(result_data_i), .freeze_monitor_results_i(freeze_monitor_results_i),
  .reg_rd_en_i(reg_rd_en_i), .reg_wr_en_i(reg_wr_en_i), .reg_addr_i(reg_addr_i),
  .reg_rd_data_o(reg_rd_data_o), .reg_rd_valid_o(reg_rd_valid_o),
  .reg_addr_hit_o(reg_addr_hit_o), .reg_wr_ack_o(reg_wr_ack_o),
  .result_dropped_o(result_dropped_o));
`default_nettype wire
